// ===== dv/rtr_host.sv
/* host model of the register port, one access at a time.
 assumes reg_rdata is valid one cycle after the read edge. */
`timescale 1ns/1ps
`default_nettype none
module rtr_host (
    input  wire logic       clk,
    output var  logic       reg_wr = 1'b0,
    output var  logic       reg_rd = 1'b0,
    output var  logic [7:0] reg_addr = 8'h00,
    output var  logic [7:0] reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata
);
    task w(input [7:0] a, input [7:0] v);
        @(posedge clk) #1;
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(posedge clk) #1;
        {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'b0};
    endtask
    task r(input [7:0] a, output [7:0] v);
        @(posedge clk) #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge clk) #1;
        {reg_addr, reg_rd} = {~a, 1'b0};
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/rtr_regs_monitor.sv
/* port checker for rtr_regs.
 assumes clk, sys_rst and the port names of rtr_regs. */
`timescale 1ns/1ps
`default_nettype none
module rtr_regs_monitor #(parameter W = 13) (
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_addr,
    input wire logic [7:0]   reg_rdata,
    input wire logic         conv_valid,
    input wire logic         unsigned_format_select,
    input wire logic [W-1:0] signed_temp,
    input wire logic         signed_valid,
    input wire logic [W-1:0] high_limit,
    input wire logic         high_limit_unsigned
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sv_pulse_a: assert property (conv_valid |=> signed_valid) else $error("valid missing");
    sv_clear_a: assert property (!conv_valid |=> !signed_valid) else $error("valid stuck");
    st_hold_a: assert property (!conv_valid |=> $stable(signed_temp)) else $error("sum moved");
    hl_fmt_a: assert property (high_limit_unsigned == unsigned_format_select) else $error("format");
    hl_low_a: assert property (high_limit[1:0] == 2'h0) else $error("limit low bits");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    lo_zero_a: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata[2:0] == 3'h0) else $error("lo");
    ofs_zero_a: assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata[4:0] == 5'h0) else $error("ofs");
    hl_frac_a: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata[4:0] == 5'h0) else $error("hl");
endmodule
bind rtr_regs rtr_regs_monitor #(.W(W)) mon (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .reg_rd                 (reg_rd),
    .reg_addr               (reg_addr),
    .reg_rdata              (reg_rdata),
    .conv_valid             (conv_valid),
    .unsigned_format_select (unsigned_format_select),
    .signed_temp            (signed_temp),
    .signed_valid           (signed_valid),
    .high_limit             (high_limit),
    .high_limit_unsigned    (high_limit_unsigned)
);
`default_nettype wire

// ===== dv/rtr_regs_tb_top.sv
/* bench for rtr_regs: host model on the register port, bench drives the converter side.
 assumes clk at 4 ns. */
`timescale 1ns/1ps
`default_nettype none
module remote_temp_result_offset_setpoint_regs_tb_top;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        conv_valid = 1'b0;
    logic        filter_en = 1'b0;
    logic        fmt = 1'b0;
    logic [12:0] cu = 13'h0000;
    logic [12:0] cr = 13'h0000;
    wire         wr, rd, sv, hlu;
    wire  [7:0]  addr, wd, rdat;
    wire  [12:0] st, hl;
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #2 clk = ~clk;
    rtr_regs #(.W(13)) dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdat), .conv_valid(conv_valid), .conv_unsigned(cu), .conv_raw(cr),
        .filter_en(filter_en), .unsigned_format_select(fmt), .signed_temp(st), .signed_valid(sv),
        .high_limit(hl), .high_limit_unsigned(hlu));
    rtr_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat));
    task chk(input [15:0] g, input [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        logic [7:0] v;
        host.r(a, v);
        chk(v, e);
    endtask
    task cv(input [12:0] u, input [12:0] r);
        @(posedge clk) #1;
        {cu, cr, conv_valid} = {u, r, 1'b1};
        @(posedge clk) #1;
        conv_valid = 1'b0;
    endtask
    task t_regs;
        chk(hl, 13'h0d20);
        chk(hlu, 1'b0);
        rc(8'h07, 8'h69);
        rc(8'h11, 8'h00);
        rc(8'h12, 8'h00);
        rc(8'h13, 8'h00);
        host.w(8'h11, 8'hff);
        host.w(8'h12, 8'hff);
        host.w(8'h13, 8'hff);
        host.w(8'h07, 8'h80);
        rc(8'h11, 8'hff);
        rc(8'h12, 8'he0);
        rc(8'h13, 8'he0);
    endtask
    task t_conv;
        cv(13'h1fff, 13'h0100);
        chk(sv, 1'b1);
        chk(st, 13'h00fc);
        @(posedge clk) #1;
        chk(sv, 1'b0);
        host.w(8'h31, 8'h55);
        rc(8'h31, 8'hff);
        rc(8'h32, 8'he0);
        filter_en = 1'b1;
        cv(13'h0a2d, 13'h1f00);
        chk(st, 13'h1efc);
        rc(8'h31, 8'h51);
        cv(13'h1fff, 13'h0000);
        rc(8'h32, 8'h68);
        rc(8'h31, 8'hff);
        rc(8'h32, 8'hf8);
    endtask
    task t_fmt;
        fmt = 1'b1;
        @(posedge clk) #1;
        chk(hlu, 1'b1);
        chk(hl, 13'h101c);
    endtask
    task t_rst;
        host.w(8'h11, 8'h3c);
        host.w(8'h07, 8'h20);
        @(posedge clk) #1;
        sys_rst = 1'b1;
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk(rdat, 8'h00);
        chk(sv, 1'b0);
        chk(st, 13'h0000);
        chk(hl, 13'h0d20);
        rc(8'h11, 8'h00);
        rc(8'h12, 8'h00);
        rc(8'h07, 8'h69);
        rc(8'h13, 8'h00);
        rc(8'h32, 8'h00);
    endtask
    task test_done;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_regs;
        t_conv;
        t_fmt;
        t_rst;
        test_done;
    end
endmodule
`default_nettype wire

// ===== verilog/rtr_consts.vh
/*
 register map, field positions and reset values for the remote result,
 offset and high-limit register bank.
 assumes the includer supplies clk/sys_rst and an 8-bit register port.
*/
// Contract
// - unsigned upper byte, bit7 weighs 128 degrees
// - lower byte bits 7..5 weigh half to eighth
// - filter off forces lower bits 1:0 to 00
// - filter on gives bits 1:0 finer weights
// - unused low field reads as zero
// - signed reading equals converter output plus offset
// - offset: full upper byte, three fraction bits
// - offset writable, readable, zero at power-on
// - high limit upper resets to 105 degrees
// - high limit format follows format-select bit
// - high limit fraction bits 7:5, rest zero
// - signed format: bit7 sign, bit6 64 degrees
`ifndef RTR_CONSTS_VH
`define RTR_CONSTS_VH

`define RTR_ADDR_W          8
`define RTR_HI_LIM_UPPER    8'h07
`define RTR_OFS_UPPER       8'h11
`define RTR_OFS_LOWER       8'h12
`define RTR_HI_LIM_LOWER    8'h13
`define RTR_UNS_UPPER       8'h31
`define RTR_UNS_LOWER       8'h32

`define RTR_HI_LIM_UPPER_RST 8'h69
`define RTR_OFS_UPPER_RST    8'h00
`define RTR_FRAC3_RST        3'h0

`define RTR_FRAC3_MSB       7
`define RTR_FRAC3_LSB       5
`define RTR_EXT_MSB         1
`define RTR_EXT_LSB         0
`define RTR_UNS_INT_LSB     5
`define RTR_UNS_FRAC_MSB    4
`define RTR_UNS_FRAC_LSB    2

`endif

// ===== verilog/rtr_offset_add.v
/*
 adds the two's-complement offset to the converter output.
 assumes 13-bit result words: 8 integer bits, 5 fraction bits.
*/
`timescale 1ns/1ps
`default_nettype none

module rtr_offset_add #(
    parameter W = 13
) (
    input  wire [W-1:0] conv_val,
    input  wire [W-1:0] offset_val,
    output wire [W-1:0] sum_val
);

    // two's-complement add, wraps at W bits
    assign sum_val = conv_val + offset_val;

endmodule

`default_nettype wire

// ===== verilog/rtr_regs.v
/*
 remote temperature result, offset and high-limit register bank.
 assumes a synchronous 8-bit register port from the serial interface and
 a one-cycle result strobe from the converter loop, both on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtr_consts.vh"

module rtr_regs #(
    parameter W = 13
) (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [`RTR_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    output wire [7:0]             reg_rdata,
    input  wire                   conv_valid,
    input  wire [W-1:0]           conv_unsigned,
    input  wire [W-1:0]           conv_raw,
    input  wire                   filter_en,
    input  wire                   unsigned_format_select,
    output wire [W-1:0]           signed_temp,
    output wire                   signed_valid,
    output wire [W-1:0]           high_limit,
    output wire                   high_limit_unsigned
);

    // converter results and their snapshot
    reg  [7:0]   unsigned_temp_upper_bits_ff;
    reg  [4:0]   unsigned_temp_lower_bits_ff;
    reg  [4:0]   lower_snap_ff;
    reg  [W-1:0] signed_temp_ff;
    reg          signed_valid_ff;
    // host-writable registers
    reg  [7:0]   offset_upper_bits_ff;
    reg  [2:0]   offset_frac_ff;
    reg  [7:0]   high_limit_upper_bits_ff;
    reg  [2:0]   high_limit_fraction_bits_ff;
    // read path
    reg  [7:0]   rdata_ff;
    reg  [7:0]   nxt_rdata;
    // next values and decodes
    wire [7:0]   nxt_unsigned_upper;
    wire [4:0]   nxt_unsigned_lower;
    wire [W-1:0] nxt_signed_temp;
    wire [W-1:0] offset_word;
    wire [1:0]   unsigned_temp_extra_fraction;
    wire         wr_ofs_upper;
    wire         wr_ofs_lower;
    wire         wr_hl_upper;
    wire         wr_hl_lower;
    wire         rd_uns_upper;

    // 3-bit fraction field packed in the top of a byte, low field zero
    function [7:0] frac_byte;
        input [2:0] f;
        begin
            frac_byte = {f, 5'h00};
        end
    endfunction

    // strobe qualified by one register address
    function addr_hit;
        input                   strobe;
        input [`RTR_ADDR_W-1:0] a;
        input [`RTR_ADDR_W-1:0] target;
        begin
            addr_hit = strobe && (a == target);
        end
    endfunction

    // writable fraction field of a write byte
    function [2:0] frac_field;
        input [7:0] d;
        begin
            frac_field = d[`RTR_FRAC3_MSB:`RTR_FRAC3_LSB];
        end
    endfunction

    // one write enable per writable register, one read decode
    assign wr_ofs_upper = addr_hit(reg_wr, reg_addr, `RTR_OFS_UPPER);
    assign wr_ofs_lower = addr_hit(reg_wr, reg_addr, `RTR_OFS_LOWER);
    assign wr_hl_upper  = addr_hit(reg_wr, reg_addr, `RTR_HI_LIM_UPPER);
    assign wr_hl_lower  = addr_hit(reg_wr, reg_addr, `RTR_HI_LIM_LOWER);
    assign rd_uns_upper = addr_hit(reg_rd, reg_addr, `RTR_UNS_UPPER);

    // extended fraction only while filtering
    assign unsigned_temp_extra_fraction = filter_en ?
        conv_unsigned[`RTR_EXT_MSB:`RTR_EXT_LSB] : 2'h0;
    assign nxt_unsigned_upper = conv_unsigned[`RTR_UNS_INT_LSB+7:`RTR_UNS_INT_LSB];
    assign nxt_unsigned_lower = {conv_unsigned[`RTR_UNS_FRAC_MSB:`RTR_UNS_FRAC_LSB],
                                 unsigned_temp_extra_fraction};

    // offset in signed filter-off format: extra fraction bits zero
    assign offset_word = {offset_upper_bits_ff, offset_frac_ff, 2'h0};

    rtr_offset_add #(
        .W (W)
    ) u_add (
        .conv_val   (conv_raw),
        .offset_val (offset_word),
        .sum_val    (nxt_signed_temp)
    );

    // outputs straight from the registers, high_limit_unsigned straight from unsigned_format_select
    assign reg_rdata           = rdata_ff;
    assign signed_temp         = signed_temp_ff;
    assign signed_valid        = signed_valid_ff;
    assign high_limit          = {high_limit_upper_bits_ff, high_limit_fraction_bits_ff, 2'h0};
    assign high_limit_unsigned = unsigned_format_select;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unsigned_temp_upper_bits_ff <= 8'h00;
        end else if (conv_valid) begin
            unsigned_temp_upper_bits_ff <= nxt_unsigned_upper;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unsigned_temp_lower_bits_ff <= 5'h00;
        end else if (conv_valid) begin
            unsigned_temp_lower_bits_ff <= nxt_unsigned_lower;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            signed_temp_ff <= {W{1'b0}};
        end else if (conv_valid) begin
            signed_temp_ff <= nxt_signed_temp;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            signed_valid_ff <= 1'b0;
        end else begin
            signed_valid_ff <= conv_valid;
        end
    end

    // upper-byte read freezes the matching lower byte
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lower_snap_ff <= 5'h00;
        end else if (rd_uns_upper) begin
            lower_snap_ff <= unsigned_temp_lower_bits_ff;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            offset_upper_bits_ff <= `RTR_OFS_UPPER_RST;
        end else if (wr_ofs_upper) begin
            offset_upper_bits_ff <= reg_wdata;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            offset_frac_ff <= `RTR_FRAC3_RST;
        end else if (wr_ofs_lower) begin
            offset_frac_ff <= frac_field(reg_wdata);
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_limit_upper_bits_ff <= `RTR_HI_LIM_UPPER_RST;
        end else if (wr_hl_upper) begin
            high_limit_upper_bits_ff <= reg_wdata;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_limit_fraction_bits_ff <= `RTR_FRAC3_RST;
        end else if (wr_hl_lower) begin
            high_limit_fraction_bits_ff <= frac_field(reg_wdata);
        end
    end

    always @* begin
        case (reg_addr)
            `RTR_UNS_UPPER: begin
                nxt_rdata = unsigned_temp_upper_bits_ff;
            end
            `RTR_UNS_LOWER: begin
                nxt_rdata = {lower_snap_ff, 3'h0};
            end
            `RTR_OFS_UPPER: begin
                nxt_rdata = offset_upper_bits_ff;
            end
            `RTR_OFS_LOWER: begin
                nxt_rdata = frac_byte(offset_frac_ff);
            end
            `RTR_HI_LIM_UPPER: begin
                nxt_rdata = high_limit_upper_bits_ff;
            end
            `RTR_HI_LIM_LOWER: begin
                nxt_rdata = frac_byte(high_limit_fraction_bits_ff);
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule

`default_nettype wire
